/* core/pcg_pkg.sv */
package pcg_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [31:0] GATE_ADDR        = 32'he01fc0c4;
  localparam logic [31:0] SEQ_CTRL_ADDR    = 32'he01fc0c8;
  localparam logic [31:0] SEQ_STATUS_ADDR  = 32'he01fc0cc;
  localparam logic [31:0] BOOT_VECTOR      = 32'h00000000;

  // ****************************************************************
  // gating fields
  // ****************************************************************
  localparam int TIMER0_GATE_BIT           = 1;
  localparam int TIMER1_GATE_BIT           = 2;
  localparam int UART_FIRST_GATE_BIT       = 3;
  localparam int UART_SECOND_GATE_BIT      = 4;
  localparam int PWM_GATE_BIT              = 5;
  localparam int I2C_FIRST_GATE_BIT        = 7;
  localparam int SPI_FIRST_GATE_BIT        = 8;
  localparam int RTC_GATE_BIT              = 9;
  localparam int SYNC_SERIAL_GATE_BIT      = 10;
  localparam int CONVERTER_FIRST_GATE_BIT  = 12;
  localparam int I2C_SECOND_GATE_BIT       = 19;
  localparam int CONVERTER_SECOND_GATE_BIT = 20;
  localparam logic [31:0] GATE_IMPL_MASK   = 32'h001817be;
  localparam logic [31:0] GATE_RESET_FULL  = 32'h001817be;
  localparam logic [31:0] GATE_RESET_SMALL = 32'h000817be;

  // ****************************************************************
  // control / status fields
  // ****************************************************************
  localparam int CTRL_FLASH_BUSY_BIT       = 0;
  localparam int STAT_EXT_BIT              = 0;
  localparam int STAT_WDT_BIT              = 1;
  localparam int STAT_BROWNOUT_BIT         = 2;
  localparam int STAT_RUN_BIT              = 3;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_MHZ                   = 200;
  localparam int GLITCH_NS                 = 100;
  localparam int GLITCH_CYCLES             = (GLITCH_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_CYCLES               = 4096;
  localparam int SETTLE_CYCLES             = 64;

  // ****************************************************************
  // types
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY         = 2'h0;
  localparam logic [1:0] RESP_SLVERR       = 2'h2;

  typedef struct packed {
    logic       ext;
    logic       wdt;
    logic       brownout;
  } pcg_src_t;

  typedef enum {
    SEQ_HOLD,
    SEQ_WAKE,
    SEQ_SETTLE,
    SEQ_RUN
  } pcg_seq_t;

endpackage : pcg_pkg

/* core/pcg_sync.sv */
`timescale 1ns/1ps
module pcg_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // data
  input  wire logic [WIDTH-1:0] d,
  output      logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;

  // two-stage synchroniser for pins
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      meta_reg <= '0;
      q        <= '0;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule : pcg_sync

/* core/pcg_glitch_filter.sv */
`timescale 1ns/1ps
module pcg_glitch_filter #(
  parameter int CYCLES = 20
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // level in and filtered level out
  input  wire logic level,
  output      logic filtered
);

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  wire           differs = level != filtered;
  wire           done    = count_reg == CW'(CYCLES - 1);

  assign count_next = (!differs || done) ? '0 : count_reg + 1'b1;

  // output follows only after a stable run of CYCLES
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      count_reg <= '0;
      filtered  <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      if (differs && done)
        filtered <= level;
    end
  end

endmodule : pcg_glitch_filter

/* core/pcg_top.sv */
// Operation
// - bit 1 runs clock, 0 gates it
// - watchdog, gpio, pinmux, sysctl always clocked
// - gated peripheral accesses are invalid
// - bit 1 timer0, bit 2 timer1
// - bits 3,4 uarts, bit 5 pwm
// - bit 7 i2c, 8 spi, 9 rtc
// - bit 10 sync serial, 19 second i2c
// - reserved bits: write zero, read undefined
// - all implemented bits set after reset, except bit 20 in the small variant
// - pin, watchdog, brownout all assert reset
// - reset held through wake-up timer
// - glitch filter on external pin
// - release with all registers initialised
// - config latches load on external reset only
// - flash busy delays reset completion
`timescale 1ns/1ps
module pcg_top #(
  parameter int          WAKE_CYCLES   = pcg_pkg::WAKE_CYCLES,
  parameter int          SETTLE_CYCLES = pcg_pkg::SETTLE_CYCLES,
  parameter int          CFG_WIDTH     = 2,
  parameter bit          SMALL_VARIANT = 1'b0
) (
  // clock and reset
  input  wire logic                 CLK,
  input  wire logic                 RESET,
  // reset sources
  input  wire logic                 RESET_PIN_N,
  input  wire logic                 WDT_RESET,
  input  wire logic                 BROWNOUT_RESET,
  input  wire logic                 OSC_READY,
  input  wire logic                 FLASH_BUSY,
  input  wire logic [CFG_WIDTH-1:0] CFG_PINS,
  // axi4-lite write address
  input  wire logic [31:0]          AWADDR,
  input  wire logic                 AWVALID,
  output      logic                 AWREADY,
  // axi4-lite write data
  input  wire logic [31:0]          WDATA,
  input  wire logic [3:0]           WSTRB,
  input  wire logic                 WVALID,
  output      logic                 WREADY,
  // axi4-lite write response
  output      logic [1:0]           BRESP,
  output      logic                 BVALID,
  input  wire logic                 BREADY,
  // axi4-lite read address
  input  wire logic [31:0]          ARADDR,
  input  wire logic                 ARVALID,
  output      logic                 ARREADY,
  // axi4-lite read data
  output      logic [31:0]          RDATA,
  output      logic [1:0]           RRESP,
  output      logic                 RVALID,
  input  wire logic                 RREADY,
  // peripheral clock enables and resets
  output      logic [31:0]          PERIPH_CLK_EN,
  output      logic                 ALWAYS_ON_CLK_EN,
  output      logic [31:0]          PERIPH_ACCESS_OK,
  output      logic                 CHIP_RESET,
  output      logic                 FLASH_ABORT,
  output      logic [31:0]          BOOT_ADDR,
  output      logic [CFG_WIDTH-1:0] CFG_LATCH
);

  // ****************************************************************
  // reset source conditioning
  // ****************************************************************
  logic [4:0] raw_sync;
  logic       pin_asserted;
  logic       wdt_s;
  logic       bod_s;
  logic       osc_s;
  logic       flash_s;
  logic [CFG_WIDTH-1:0] cfg_s;

  pcg_sync #(.WIDTH(5)) u_sync (
    .clk   (CLK),
    .reset (RESET),
    .d     ({~RESET_PIN_N, WDT_RESET, BROWNOUT_RESET, OSC_READY, FLASH_BUSY}),
    .q     (raw_sync)
  );

  pcg_sync #(.WIDTH(CFG_WIDTH)) u_cfg_sync (
    .clk   (CLK),
    .reset (RESET),
    .d     (CFG_PINS),
    .q     (cfg_s)
  );

  pcg_glitch_filter #(.CYCLES(pcg_pkg::GLITCH_CYCLES)) u_filter (
    .clk      (CLK),
    .reset    (RESET),
    .level    (raw_sync[4]),
    .filtered (pin_asserted)
  );

  assign wdt_s   = raw_sync[3];
  assign bod_s   = raw_sync[2];
  assign osc_s   = raw_sync[1];
  assign flash_s = raw_sync[0];

  pcg_pkg::pcg_src_t src;
  assign src = '{
    ext:      pin_asserted,
    wdt:      wdt_s,
    brownout: bod_s
  };
  wire any_src = src.ext | src.wdt | src.brownout;

  // ****************************************************************
  // reset sequencer
  // ****************************************************************
  localparam int TW = $clog2(WAKE_CYCLES + SETTLE_CYCLES + 1);

  pcg_pkg::pcg_seq_t state_reg;
  pcg_pkg::pcg_seq_t state_next;
  logic [TW-1:0]     timer_reg;
  logic [TW-1:0]     timer_next;
  logic              ext_seen_reg;
  wire               wake_done   = timer_reg == TW'(WAKE_CYCLES - 1);
  wire               settle_done = timer_reg == TW'(SETTLE_CYCLES - 1);

  always_comb
  begin
    state_next = state_reg;
    timer_next = timer_reg + 1'b1;
    case (state_reg)
      pcg_pkg::SEQ_HOLD:
      begin
        timer_next = '0;
        if (!any_src && osc_s)
          state_next = pcg_pkg::SEQ_WAKE;
      end
      pcg_pkg::SEQ_WAKE:
      begin
        if (wake_done)
        begin
          timer_next = '0;
          state_next = pcg_pkg::SEQ_SETTLE;
        end
      end
      pcg_pkg::SEQ_SETTLE:
      begin
        if (flash_s)
          timer_next = '0;
        else if (settle_done)
          state_next = pcg_pkg::SEQ_RUN;
      end
      pcg_pkg::SEQ_RUN:
        timer_next = '0;
      default:
        state_next = pcg_pkg::SEQ_HOLD;
    endcase
    if (any_src || !osc_s)
    begin
      state_next = pcg_pkg::SEQ_HOLD;
      timer_next = '0;
    end
  end

  wire in_reset = state_next != pcg_pkg::SEQ_RUN;

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      state_reg    <= pcg_pkg::SEQ_HOLD;
      timer_reg    <= '0;
      ext_seen_reg <= 1'b0;
    end
    else
    begin
      state_reg    <= state_next;
      timer_reg    <= timer_next;
      ext_seen_reg <= src.ext;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      CHIP_RESET  <= 1'b1;
      FLASH_ABORT <= 1'b0;
      BOOT_ADDR   <= pcg_pkg::BOOT_VECTOR;
      CFG_LATCH   <= '0;
    end
    else
    begin
      CHIP_RESET  <= in_reset;
      FLASH_ABORT <= (state_reg == pcg_pkg::SEQ_RUN) && any_src && flash_s;
      BOOT_ADDR   <= pcg_pkg::BOOT_VECTOR;
      if (src.ext)
        CFG_LATCH <= cfg_s;
    end
  end

  // ****************************************************************
  // axi4-lite slave
  // ****************************************************************
  logic [31:0] gate_reg;
  logic [31:0] aw_addr_reg;
  logic        aw_have_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        w_have_reg;
  logic        flash_req_reg;

  wire         aw_take  = AWVALID && AWREADY;
  wire         w_take   = WVALID && WREADY;
  wire         do_write = aw_have_reg && w_have_reg && !BVALID;
  wire         ar_take  = ARVALID && ARREADY;
  wire         hit_gate = aw_addr_reg == pcg_pkg::GATE_ADDR;
  wire         hit_ctrl = aw_addr_reg == pcg_pkg::SEQ_CTRL_ADDR;
  wire         wr_ok    = hit_gate || hit_ctrl;

  logic [31:0] strb_mask;
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      strb_mask[i*8 +: 8] = {8{w_strb_reg[i]}};
  end

  // implemented gate positions
  wire [31:0] gate_impl  = (32'h1 << pcg_pkg::TIMER0_GATE_BIT)
                         | (32'h1 << pcg_pkg::TIMER1_GATE_BIT)
                         | (32'h1 << pcg_pkg::UART_FIRST_GATE_BIT)
                         | (32'h1 << pcg_pkg::UART_SECOND_GATE_BIT)
                         | (32'h1 << pcg_pkg::PWM_GATE_BIT)
                         | (32'h1 << pcg_pkg::I2C_FIRST_GATE_BIT)
                         | (32'h1 << pcg_pkg::SPI_FIRST_GATE_BIT)
                         | (32'h1 << pcg_pkg::RTC_GATE_BIT)
                         | (32'h1 << pcg_pkg::SYNC_SERIAL_GATE_BIT)
                         | (32'h1 << pcg_pkg::CONVERTER_FIRST_GATE_BIT)
                         | (32'h1 << pcg_pkg::I2C_SECOND_GATE_BIT)
                         | (32'h1 << pcg_pkg::CONVERTER_SECOND_GATE_BIT);
  wire [31:0] gate_reset = SMALL_VARIANT ? pcg_pkg::GATE_RESET_SMALL
                                         : pcg_pkg::GATE_RESET_FULL;
  wire [31:0] gate_wr    = (w_data_reg & strb_mask) | (gate_reg & ~strb_mask);
  wire [31:0] gate_next  = gate_wr & gate_impl;

  // status and control words, fields placed by position
  logic [31:0] status_word;
  logic [31:0] ctrl_word;
  always_comb
  begin
    status_word                             = 32'h00000000;
    status_word[pcg_pkg::STAT_EXT_BIT]      = ext_seen_reg;
    status_word[pcg_pkg::STAT_WDT_BIT]      = src.wdt;
    status_word[pcg_pkg::STAT_BROWNOUT_BIT] = src.brownout;
    status_word[pcg_pkg::STAT_RUN_BIT]      = state_reg == pcg_pkg::SEQ_RUN;
  end

  always_comb
  begin
    ctrl_word                               = 32'h00000000;
    ctrl_word[pcg_pkg::CTRL_FLASH_BUSY_BIT] = flash_req_reg;
  end

  wire        rd_gate   = ARADDR == pcg_pkg::GATE_ADDR;
  wire        rd_ctrl   = ARADDR == pcg_pkg::SEQ_CTRL_ADDR;
  wire        rd_stat   = ARADDR == pcg_pkg::SEQ_STATUS_ADDR;
  wire [31:0] rd_data   = rd_gate ? gate_reg :
                          rd_ctrl ? ctrl_word :
                          rd_stat ? status_word : 32'h00000000;
  wire        rd_ok     = rd_gate || rd_ctrl || rd_stat;

  always_ff @(posedge CLK)
  begin
    if (RESET || CHIP_RESET)
    begin
      gate_reg      <= gate_reset;
      flash_req_reg <= 1'b0;
      AWREADY       <= 1'b0;
      WREADY        <= 1'b0;
      ARREADY       <= 1'b0;
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      aw_addr_reg   <= 32'h00000000;
      w_data_reg    <= 32'h00000000;
      w_strb_reg    <= 4'h0;
      BVALID        <= 1'b0;
      BRESP         <= pcg_pkg::RESP_OKAY;
      RVALID        <= 1'b0;
      RRESP         <= pcg_pkg::RESP_OKAY;
      RDATA         <= 32'h00000000;
    end
    else
    begin
      AWREADY <= !aw_have_reg && !aw_take && !BVALID;
      WREADY  <= !w_have_reg && !w_take && !BVALID;
      ARREADY <= !RVALID && !ar_take;
      if (aw_take)
      begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= AWADDR;
      end
      if (w_take)
      begin
        w_have_reg <= 1'b1;
        w_data_reg <= WDATA;
        w_strb_reg <= WSTRB;
      end
      if (do_write)
      begin
        aw_have_reg <= 1'b0;
        w_have_reg  <= 1'b0;
        BVALID      <= 1'b1;
        BRESP       <= wr_ok ? pcg_pkg::RESP_OKAY : pcg_pkg::RESP_SLVERR;
        if (hit_gate)
          gate_reg <= gate_next;
        if (hit_ctrl && w_strb_reg[0])
          flash_req_reg <= w_data_reg[pcg_pkg::CTRL_FLASH_BUSY_BIT];
      end
      else if (BVALID && BREADY)
        BVALID <= 1'b0;
      if (ar_take)
      begin
        RVALID <= 1'b1;
        RDATA  <= rd_data;
        RRESP  <= rd_ok ? pcg_pkg::RESP_OKAY : pcg_pkg::RESP_SLVERR;
      end
      else if (RVALID && RREADY)
        RVALID <= 1'b0;
    end
  end

  // ****************************************************************
  // peripheral clock enables
  // ****************************************************************
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      PERIPH_CLK_EN    <= gate_reset;
      PERIPH_ACCESS_OK <= 32'h00000000;
      ALWAYS_ON_CLK_EN <= 1'b1;
    end
    else
    begin
      PERIPH_CLK_EN    <= gate_reg & gate_impl;
      PERIPH_ACCESS_OK <= CHIP_RESET ? 32'h00000000 : gate_reg;
      ALWAYS_ON_CLK_EN <= 1'b1;
    end
  end

endmodule : pcg_top

/* dv/pcg_top_assertions.sv */
`timescale 1ns/1ps
module pcg_top_assertions #(
  parameter int WAKE_CYCLES   = pcg_pkg::WAKE_CYCLES,
  parameter int SETTLE_CYCLES = pcg_pkg::SETTLE_CYCLES,
  parameter int CFG_WIDTH     = 2,
  parameter bit SMALL_VARIANT = 1'b0
) (
  // clock and reset
  input wire logic                 CLK,
  input wire logic                 RESET,
  // reset sources
  input wire logic                 RESET_PIN_N,
  input wire logic                 WDT_RESET,
  input wire logic                 BROWNOUT_RESET,
  input wire logic                 OSC_READY,
  input wire logic                 FLASH_BUSY,
  // outputs
  input wire logic [31:0]          PERIPH_CLK_EN,
  input wire logic [31:0]          PERIPH_ACCESS_OK,
  input wire logic                 CHIP_RESET,
  input wire logic [CFG_WIDTH-1:0] CFG_LATCH
);
  // ****
  // saturating run-length counters
  // ****
  logic [15:0] hold_cnt;
  logic [7:0]  idle_cnt;
  logic [7:0]  pin_cnt;
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      hold_cnt <= '0;
      idle_cnt <= '0;
      pin_cnt  <= '0;
    end
    else
    begin
      hold_cnt <= CHIP_RESET ? hold_cnt + {15'h0, ~&hold_cnt} : '0;
      idle_cnt <= FLASH_BUSY ? '0 : idle_cnt + {7'h0, ~&idle_cnt};
      pin_cnt  <= RESET_PIN_N ? pin_cnt + {7'h0, ~&pin_cnt} : '0;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  property p_reserved_off;
    (PERIPH_CLK_EN & ~pcg_pkg::GATE_IMPL_MASK) == 32'h0;
  endproperty
  a_reserved_off: assert property (p_reserved_off) else $error("reserved enable set");
  property p_no_access_in_reset;
    CHIP_RESET [*2] |-> PERIPH_ACCESS_OK == 32'h0;
  endproperty
  a_no_access_in_reset: assert property (p_no_access_in_reset) else $error("access ok");
  property p_source_resets;
    WDT_RESET || BROWNOUT_RESET |-> ##[1:8] CHIP_RESET;
  endproperty
  a_source_resets: assert property (p_source_resets) else $error("no chip reset");
  property p_osc_holds;
    !OSC_READY |-> ##[1:8] CHIP_RESET;
  endproperty
  a_osc_holds: assert property (p_osc_holds) else $error("run without osc");
  property p_wake_length;
    $fell(CHIP_RESET) |-> hold_cnt >= WAKE_CYCLES + SETTLE_CYCLES;
  endproperty
  a_wake_length: assert property (p_wake_length) else $error("wake too short");
  property p_release_value;
    $fell(CHIP_RESET) |-> PERIPH_CLK_EN ==
      (SMALL_VARIANT ? pcg_pkg::GATE_RESET_SMALL : pcg_pkg::GATE_RESET_FULL);
  endproperty
  a_release_value: assert property (p_release_value) else $error("bad gate value");
  property p_latch_kept;
    pin_cnt > 8'd32 |-> $stable(CFG_LATCH);
  endproperty
  a_latch_kept: assert property (p_latch_kept) else $error("latch changed");
  property p_flash_settle;
    $fell(CHIP_RESET) |-> idle_cnt >= SETTLE_CYCLES;
  endproperty
  a_flash_settle: assert property (p_flash_settle) else $error("flash not settled");
endmodule : pcg_top_assertions

bind pcg_top pcg_top_assertions #(
  .WAKE_CYCLES(WAKE_CYCLES), .SETTLE_CYCLES(SETTLE_CYCLES),
  .CFG_WIDTH(CFG_WIDTH), .SMALL_VARIANT(SMALL_VARIANT)
) u_pcg_top_assertions (
  .CLK(CLK), .RESET(RESET), .RESET_PIN_N(RESET_PIN_N), .WDT_RESET(WDT_RESET),
  .BROWNOUT_RESET(BROWNOUT_RESET), .OSC_READY(OSC_READY), .FLASH_BUSY(FLASH_BUSY),
  .PERIPH_CLK_EN(PERIPH_CLK_EN), .PERIPH_ACCESS_OK(PERIPH_ACCESS_OK),
  .CHIP_RESET(CHIP_RESET), .CFG_LATCH(CFG_LATCH)
);

/* dv/pcg_ext_reset_model.sv */
`timescale 1ns/1ps
module pcg_ext_reset_model (
  // clock
  input wire logic clk,
  // driven lines
  output logic     pin_n,
  output logic     osc_ready
);
  initial
  begin
    pin_n = 1'b1;
    osc_ready = 1'b1;
  end
  // pin held low through any oscillator stop, then for low more cycles
  task automatic press(input int low, input int osc_off);
    @(posedge clk);
    pin_n <= 1'b0;
    if (osc_off > 0)
    begin
      osc_ready <= 1'b0;
      repeat (osc_off) @(posedge clk);
      osc_ready <= 1'b1;
    end
    repeat (low) @(posedge clk);
    pin_n <= 1'b1;
  endtask : press
endmodule : pcg_ext_reset_model

/* dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic        CLK, RESET, RESET_PIN_N, WDT_RESET, BROWNOUT_RESET, OSC_READY, FLASH_BUSY, g;
  logic [1:0]  CFG_PINS, CFG_LATCH, BRESP, RRESP, c;
  logic [31:0] AWADDR, WDATA, ARADDR, RDATA, PERIPH_CLK_EN, PERIPH_ACCESS_OK, BOOT_ADDR, v;
  logic [3:0]  WSTRB;
  logic        AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY, RVALID;
  logic        RREADY, ALWAYS_ON_CLK_EN, CHIP_RESET, FLASH_ABORT;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  int          errors, samples_checked, seed, n;
  localparam logic [31:0] M = pcg_pkg::GATE_IMPL_MASK;
  localparam logic [31:0] GA = pcg_pkg::GATE_ADDR;
  localparam logic [31:0] CA = pcg_pkg::SEQ_CTRL_ADDR;
  localparam logic [31:0] SA = pcg_pkg::SEQ_STATUS_ADDR;

  pcg_top #(.WAKE_CYCLES(16), .SETTLE_CYCLES(4)) u_pcg_top (
    .CLK(CLK), .RESET(RESET), .RESET_PIN_N(RESET_PIN_N), .WDT_RESET(WDT_RESET),
    .BROWNOUT_RESET(BROWNOUT_RESET), .OSC_READY(OSC_READY), .FLASH_BUSY(FLASH_BUSY),
    .CFG_PINS(CFG_PINS), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .PERIPH_CLK_EN(PERIPH_CLK_EN), .ALWAYS_ON_CLK_EN(ALWAYS_ON_CLK_EN),
    .PERIPH_ACCESS_OK(PERIPH_ACCESS_OK), .CHIP_RESET(CHIP_RESET),
    .FLASH_ABORT(FLASH_ABORT), .BOOT_ADDR(BOOT_ADDR), .CFG_LATCH(CFG_LATCH)
  );
  pcg_ext_reset_model u_pcg_ext_reset_model (
    .clk(CLK), .pin_n(RESET_PIN_N), .osc_ready(OSC_READY)
  );

  initial
  begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end

  task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report

  task automatic tick;
    @(posedge CLK);
    n++;
    if (n > 2000)
    begin
      errors++;
      final_report;
    end
  endtask : tick

  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back(r);
    n = 0;
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    do
    begin
      tick;
      if (AWREADY)
        AWVALID <= 1'b0;
      if (WREADY)
        WVALID <= 1'b0;
    end
    while ((AWVALID && !AWREADY) || (WVALID && !WREADY));
    do
      tick;
    while (BVALID !== 1'b1);
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    rq.push_back({r, d});
    n = 0;
    ARADDR <= a;
    ARVALID <= 1'b1;
    do
      tick;
    while (ARREADY !== 1'b1);
    ARVALID <= 1'b0;
    do
      tick;
    while (RVALID !== 1'b1);
  endtask : rd

  task automatic wait_run;
    n = 0;
    do
      tick;
    while (CHIP_RESET !== 1'b0);
  endtask : wait_run

  // ****
  // response monitor
  // ****
  always @(posedge CLK)
  begin
    if (RVALID && RREADY)
      check("rdata", {RRESP, RDATA}, rq.pop_front());
    if (BVALID && BREADY)
      check("bresp", {32'h0, BRESP}, {32'h0, bq.pop_front()});
  end

  initial
  begin
    seed = 32'h2320;
    {WDT_RESET, BROWNOUT_RESET, FLASH_BUSY, AWVALID, WVALID, ARVALID} = '0;
    {AWADDR, WDATA, ARADDR} = '0;
    {RESET, BREADY, RREADY, WSTRB, CFG_PINS} = 9'h1fd;
    repeat (3) @(posedge CLK);
    check("clk_en", PERIPH_CLK_EN, pcg_pkg::GATE_RESET_FULL);
    check("access", PERIPH_ACCESS_OK, 0);
    RESET <= 1'b0;
    wait_run;
    rd(GA, pcg_pkg::GATE_RESET_FULL, pcg_pkg::RESP_OKAY);
    $display("done reset");
    for (int i = 0; i < 36; i++)
    begin
      v = (i < 32) ? 32'h1 << i : $random(seed);
      wr(GA, v & M, pcg_pkg::RESP_OKAY);
      rd(GA, v & M, pcg_pkg::RESP_OKAY);
      check("clk_en", PERIPH_CLK_EN, v & M);
      check("access", PERIPH_ACCESS_OK, v & M);
      check("always_on", ALWAYS_ON_CLK_EN, 1'b1);
    end
    wr(32'he01fc0d0, v, pcg_pkg::RESP_SLVERR);
    rd(32'he01fc0d0, 32'h0, pcg_pkg::RESP_SLVERR);
    wr(CA, 32'h1 << pcg_pkg::CTRL_FLASH_BUSY_BIT, pcg_pkg::RESP_OKAY);
    rd(CA, 32'h1 << pcg_pkg::CTRL_FLASH_BUSY_BIT, pcg_pkg::RESP_OKAY);
    rd(SA, 32'h1 << pcg_pkg::STAT_RUN_BIT, pcg_pkg::RESP_OKAY);
    $display("done gating");
    u_pcg_ext_reset_model.press(10, 0);
    g = 1'b0;
    repeat (40) @(posedge CLK) g |= CHIP_RESET;
    check("glitch", g, 1'b0);
    rd(GA, v & M, pcg_pkg::RESP_OKAY);
    c = $random(seed);
    CFG_PINS <= c;
    u_pcg_ext_reset_model.press(40, 0);
    check("chip_reset", CHIP_RESET, 1'b1);
    wait_run;
    check("wake", n >= 20, 1'b1);
    check("cfg", CFG_LATCH, c);
    rd(GA, pcg_pkg::GATE_RESET_FULL, pcg_pkg::RESP_OKAY);
    rd(CA, 32'h0, pcg_pkg::RESP_OKAY);
    $display("done pin reset");
    CFG_PINS <= ~c;
    for (int k = 0; k < 2; k++)
    begin
      WDT_RESET <= (k == 0);
      BROWNOUT_RESET <= (k == 1);
      FLASH_BUSY <= 1'b1;
      g = 1'b0;
      repeat (10) @(posedge CLK) g |= FLASH_ABORT;
      {WDT_RESET, BROWNOUT_RESET} <= 2'h0;
      check("abort", g, 1'b1);
      repeat (30) @(posedge CLK);
      check("chip_reset", CHIP_RESET, 1'b1);
      FLASH_BUSY <= 1'b0;
      wait_run;
      check("cfg", CFG_LATCH, c);
      rd(GA, pcg_pkg::GATE_RESET_FULL, pcg_pkg::RESP_OKAY);
    end
    $display("done internal reset");
    u_pcg_ext_reset_model.press(0, 30);
    check("chip_reset", CHIP_RESET, 1'b1);
    wait_run;
    check("boot", BOOT_ADDR, pcg_pkg::BOOT_VECTOR);
    check("cfg", CFG_LATCH, {32'h0, ~c});
    $display("done oscillator");
    final_report;
  end
endmodule : tb_top
